/* hw/crsi_core.v */
// Holds the CPU program and system registers, the internal RAM blocks and
// the boot sequence that runs between reset release and the user program.
// Assumes an Avalon-MM master on clk_i and reset inputs given synchronous to it.
`timescale 1ns/10ps
`default_nettype none
`include "crsi_regs.vh"

module crsi_core #(
    parameter integer NBLK = 4,
    parameter integer BLK_AW = 4,
    parameter [15:0] BOOT_CYCLES = `CRSI_BOOT_CYCLES
) (
    input wire clk_i,
    input wire reset_i,
    input wire por_reset_i,
    input wire ext_reset_n_i,
    input wire wdt_reset_i,
    input wire clkmon_reset_i,
    input wire [8:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    output reg [31:0] zero_register_o,
    output reg [31:0] program_counter_o,
    output reg [31:0] program_status_word_o,
    output reg [31:0] exception_cause_register_o,
    output reg user_start_o,
    output reg in_reset_o
);

    localparam integer BLK_IW = 2;
    localparam integer BLK_WORDS = 1 << BLK_AW;
    localparam [1:0] ST_BOOT = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;

    reg [1:0] ctrl_r;
    reg [31:0] vector_r;
    reg [31:0] table_call_base_pointer_r;
    reg sw_req_r;
    reg ext_prev_r;
    reg [1:0] state_r;
    reg [15:0] boot_cnt_r;
    reg [31:0] rd_nxt;

    wire pin_res;
    wire int_res;
    wire sys_res;
    wire ext_fall;
    wire acc_wr;
    wire wr_ctrl;
    wire wr_vector;
    wire wr_swreset;
    wire wr_tcbp;
    wire [31:0] ctrl_merged;
    wire ram_hit;
    wire [BLK_IW-1:0] bus_blk;
    wire [BLK_AW-1:0] bus_word;
    wire boot_wr;
    wire [BLK_AW-1:0] boot_idx;
    wire [31:0] blk_rd [0:NBLK-1];

    // Every source except the registered software request forces the combined reset without waiting for a clock edge.
    assign pin_res = reset_i | por_reset_i | ~ext_reset_n_i;
    assign int_res = wdt_reset_i | clkmon_reset_i | sw_req_r;
    assign sys_res = pin_res | int_res;
    // Only the first cycle of a low pin counts as the cutting edge, so a held pin hits no later write.
    assign ext_fall = ext_prev_r & ~ext_reset_n_i;
    assign acc_wr = avs_write_i & ~avs_waitrequest_o;
    // One decode per register ties every write strobe to the accepted bus cycle.
    assign wr_ctrl = acc_wr & ~ram_hit & (avs_address_i == `CRSI_OFS_CTRL);
    assign wr_vector = acc_wr & ~ram_hit & (avs_address_i == `CRSI_OFS_VECTOR);
    assign wr_swreset = acc_wr & ~ram_hit & (avs_address_i == `CRSI_OFS_SWRESET);
    assign wr_tcbp = acc_wr & ~ram_hit & (avs_address_i == `CRSI_OFS_TCBP);
    assign ram_hit = avs_address_i[`CRSI_RAM_SEL_BIT];
    assign bus_blk = avs_address_i[2+BLK_AW +: BLK_IW];
    assign bus_word = avs_address_i[2 +: BLK_AW];
    // Scratch words in block 0 are overwritten while booting, so afterwards each reads as the boot mark ORed with its index.
    assign boot_wr = (state_r == ST_BOOT) & ~sys_res & (boot_cnt_r < BLK_WORDS);
    assign boot_idx = boot_cnt_r[BLK_AW-1:0];

    function [31:0] crsi_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] be;
        integer i;
        begin
            crsi_merge = old_v;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (be[i])
                begin
                    crsi_merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    assign ctrl_merged = crsi_merge({30'h00000000, ctrl_r}, avs_writedata_i, avs_byteenable_i);

    genvar g;
    generate
        for (g = 0; g < NBLK; g = g + 1)
        begin : gen_blk
            reg [31:0] mem [0:BLK_WORDS-1];
            integer b;
            assign blk_rd[g] = mem[bus_word];
            // Each block has its own write enable, so a cut write stays local. No reset clears it.
            always @(posedge clk_i)
            begin
                if ((g == 0) && boot_wr)
                begin
                    mem[boot_idx] <= `CRSI_BOOT_MARK | {16'h0000, boot_cnt_r};
                end
                else if (acc_wr && ram_hit && (bus_blk == g))
                begin
                    if (!sys_res)
                    begin
                        for (b = 0; b < 4; b = b + 1)
                        begin
                            if (avs_byteenable_i[b])
                            begin
                                mem[bus_word][b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
                            end
                        end
                    end
                    else if (ext_fall)
                    begin
                        mem[bus_word] <= avs_writedata_i ^ `CRSI_CORRUPT_MASK;
                    end
                    else
                    begin
                        mem[bus_word] <= mem[bus_word];
                    end
                end
            end
        end
    endgenerate
    // Writes arriving under any other reset are dropped, so memory keeps its state.
    // Only the boot writes fill block 0; nothing initialises the other arrays, so after power-on they hold whatever they held.

    always @*
    begin
        rd_nxt = 32'h00000000;
        if (ram_hit)
        begin
            rd_nxt = blk_rd[bus_blk];
        end
        else
        begin
            case (avs_address_i)
                `CRSI_OFS_CTRL: rd_nxt = {30'h00000000, ctrl_r};
                `CRSI_OFS_VECTOR: rd_nxt = vector_r;
                `CRSI_OFS_SWRESET: rd_nxt = 32'h00000000;
                `CRSI_OFS_STATUS: rd_nxt = {30'h00000000, user_start_o, in_reset_o};
                `CRSI_OFS_PC: rd_nxt = program_counter_o;
                `CRSI_OFS_PSW: rd_nxt = program_status_word_o;
                `CRSI_OFS_ECR: rd_nxt = exception_cause_register_o;
                `CRSI_OFS_ZERO: rd_nxt = zero_register_o;
                `CRSI_OFS_TCBP: rd_nxt = table_call_base_pointer_r;
                default: rd_nxt = 32'h00000000;
            endcase
        end
    end

    // One wait state per access keeps read data registered and the answer fixed.
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
        end
        else
        begin
            if (avs_waitrequest_o && (avs_read_i || avs_write_i))
            begin
                avs_waitrequest_o <= 1'b0;
            end
            else
            begin
                avs_waitrequest_o <= 1'b1;
            end
            if (avs_waitrequest_o && avs_read_i)
            begin
                avs_readdata_o <= rd_nxt;
            end
        end
    end

    // The vector survives every reset except reset_i, standing in for non-volatile storage.
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ctrl_r <= `CRSI_CTRL_RST;
            vector_r <= `CRSI_VECTOR_RST;
            sw_req_r <= 1'b0;
            ext_prev_r <= 1'b1;
            in_reset_o <= 1'b1;
        end
        else
        begin
            ext_prev_r <= ext_reset_n_i;
            in_reset_o <= sys_res;
            sw_req_r <= wr_swreset;
            if (wr_ctrl)
            begin
                ctrl_r <= ctrl_merged[1:0];
            end
            if (wr_vector)
            begin
                vector_r <= crsi_merge(vector_r, avs_writedata_i, avs_byteenable_i);
            end
        end
    end

    // Save state is deliberately left without reset; software must load it before use.
    always @(posedge clk_i)
    begin
        if (wr_tcbp)
        begin
            table_call_base_pointer_r <= crsi_merge(table_call_base_pointer_r, avs_writedata_i, avs_byteenable_i);
        end
    end

    // The combined reset is asynchronous here so the core holds even with the clock stopped.
    always @(posedge clk_i or posedge sys_res)
    begin
        if (sys_res)
        begin
            zero_register_o <= `CRSI_ZERO_RST;
            program_counter_o <= `CRSI_PC_RST;
            exception_cause_register_o <= `CRSI_ECR_RST;
            program_status_word_o <= `CRSI_PSW_RST;
            state_r <= ST_BOOT;
            boot_cnt_r <= 16'h0000;
            user_start_o <= 1'b0;
        end
        else
        begin
            zero_register_o <= `CRSI_ZERO_RST;
            exception_cause_register_o <= exception_cause_register_o;
            case (state_r)
                ST_BOOT:
                begin
                    if (boot_cnt_r >= BOOT_CYCLES - 16'h0001)
                    begin
                        state_r <= ST_RUN;
                        user_start_o <= 1'b1;
                        program_counter_o <= vector_r;
                        if (ctrl_r[`CRSI_CTRL_SECURE_BIT] || ctrl_r[`CRSI_CTRL_VECEN_BIT])
                        begin
                            program_status_word_o <= `CRSI_PSW_GUARDED;
                        end
                        else
                        begin
                            program_status_word_o <= `CRSI_PSW_PLAIN;
                        end
                    end
                    else
                    begin
                        boot_cnt_r <= boot_cnt_r + 16'h0001;
                    end
                end
                ST_RUN:
                begin
                    // Start values stay until the next reset, as this core models no instruction flow.
                    user_start_o <= 1'b1;
                    program_counter_o <= program_counter_o;
                    program_status_word_o <= program_status_word_o;
                end
                default:
                begin
                    state_r <= ST_BOOT;
                    boot_cnt_r <= 16'h0000;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* hw/crsi_regs.vh */
// Constants for the CPU and RAM reset state initialiser.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM register port.
`ifndef CRSI_REGS_VH
`define CRSI_REGS_VH

`define CRSI_CLK_PERIOD_NS 25
`define CRSI_BOOT_TIME_NS 2000
`define CRSI_BOOT_CYCLES ((`CRSI_BOOT_TIME_NS + `CRSI_CLK_PERIOD_NS - 1) / `CRSI_CLK_PERIOD_NS)

`define CRSI_OFS_CTRL 9'h000
`define CRSI_OFS_VECTOR 9'h004
`define CRSI_OFS_SWRESET 9'h008
`define CRSI_OFS_STATUS 9'h00C
`define CRSI_OFS_PC 9'h010
`define CRSI_OFS_PSW 9'h014
`define CRSI_OFS_ECR 9'h018
`define CRSI_OFS_ZERO 9'h01C
`define CRSI_OFS_TCBP 9'h020
`define CRSI_RAM_SEL_BIT 8

`define CRSI_CTRL_SECURE_BIT 0
`define CRSI_CTRL_VECEN_BIT 1
`define CRSI_STAT_INRESET_BIT 0
`define CRSI_STAT_RUN_BIT 1

`define CRSI_ZERO_RST 32'h00000000
`define CRSI_PC_RST 32'h00000000
`define CRSI_ECR_RST 32'h00000000
`define CRSI_PSW_RST 32'h00000020
`define CRSI_PSW_PLAIN 32'h00000020
`define CRSI_PSW_GUARDED 32'h00000021
`define CRSI_VECTOR_RST 32'h00000000
`define CRSI_CTRL_RST 2'h0
`define CRSI_CORRUPT_MASK 32'hA5A5A5A5
`define CRSI_BOOT_MARK 32'h0B00F000

`endif

/* bench/crsi_core_sva.sv */
// Checker for the reset state core, watching only its ports.
// Assumes one clock and the synchronous master reset of the core.
`timescale 1ns/10ps
`default_nettype none
`include "crsi_regs.vh"
module crsi_core_sva #(
    parameter [15:0] BOOT_CYCLES = `CRSI_BOOT_CYCLES
) (
    input wire clk_i,
    input wire reset_i,
    input wire [8:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire [31:0] zero_register_o,
    input wire [31:0] program_counter_o,
    input wire [31:0] program_status_word_o,
    input wire [31:0] exception_cause_register_o,
    input wire user_start_o,
    input wire in_reset_o
);
    localparam int BOOT_MAX = BOOT_CYCLES + 2;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    property p_zero;
        zero_register_o == `CRSI_ZERO_RST;
    endproperty
    a_zero: assert property (p_zero) else $error("zero register not zero");
    property p_ecr;
        exception_cause_register_o == `CRSI_ECR_RST;
    endproperty
    a_ecr: assert property (p_ecr) else $error("cause register not zero");
    property p_boot_state;
        !user_start_o |-> program_counter_o == `CRSI_PC_RST && program_status_word_o == `CRSI_PSW_RST;
    endproperty
    a_boot_state: assert property (p_boot_state) else $error("counter or status wrong before start");
    property p_start_psw;
        user_start_o |-> program_status_word_o inside {`CRSI_PSW_PLAIN, `CRSI_PSW_GUARDED};
    endproperty
    a_start_psw: assert property (p_start_psw) else $error("status word wrong at start");
    property p_reset_idle;
        in_reset_o |-> !user_start_o;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("running during reset");
    property p_boot_len;
        $fell(in_reset_o) |-> (!user_start_o) [*8] ##[1:BOOT_MAX] (user_start_o || in_reset_o);
    endproperty
    a_boot_len: assert property (p_boot_len) else $error("boot length wrong");
    property p_wait_one;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    property p_wait_ans;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("bus answer late");
    property p_rd_const;
        avs_read_i && !avs_waitrequest_o && avs_address_i inside {`CRSI_OFS_ZERO, `CRSI_OFS_ECR}
            |-> avs_readdata_o == 32'h00000000;
    endproperty
    a_rd_const: assert property (p_rd_const) else $error("constant register read wrong");
    c_start: cover property ($rose(user_start_o));
    c_write: cover property (avs_write_i && !avs_waitrequest_o);
    c_release: cover property ($fell(in_reset_o));
endmodule
bind crsi_core crsi_core_sva #(.BOOT_CYCLES(BOOT_CYCLES)) crsi_core_sva_inst (.clk_i(clk_i), .reset_i(reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .zero_register_o(zero_register_o),
    .program_counter_o(program_counter_o), .program_status_word_o(program_status_word_o),
    .exception_cause_register_o(exception_cause_register_o), .user_start_o(user_start_o), .in_reset_o(in_reset_o));
`default_nettype wire

/* bench/cpu_ram_reset_state_init_tb_top.sv */
// Bench for the reset state core: RAM traffic across every reset source but power-on, register reads across all but the external pin.
// Assumes the core alone, driven over Avalon-MM by this bench.
`timescale 1ns/10ps
`default_nettype none
`include "crsi_regs.vh"
module cpu_ram_reset_state_init_tb_top;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic por_i = 1'b0, ext_n = 1'b1, wdt_i = 1'b0, cm_i = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] q, vec;
    logic [31:0] mem [0:11];
    wire [31:0] rdat, zero_q, pc_q, psw_q, ecr_q;
    wire wreq, start_q, inrst_q;
    integer failures = 0, checks_done = 0, seed = 25790, i, s, n;
    initial forever #12.5 clk_i = ~clk_i;
    // A short boot keeps the run brief; it must not drop below the sixteen scratch writes.
    crsi_core #(.BOOT_CYCLES(16'h0014)) crsi_core_inst (.clk_i(clk_i), .reset_i(reset_i), .por_reset_i(por_i),
        .ext_reset_n_i(ext_n), .wdt_reset_i(wdt_i), .clkmon_reset_i(cm_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .zero_register_o(zero_q), .program_counter_o(pc_q),
        .program_status_word_o(psw_q), .exception_cause_register_o(ecr_q), .user_start_o(start_q),
        .in_reset_o(inrst_q));
    task stop_test;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            checks_done++;
            if (g !== e)
            begin
                failures++;
                $display("[FAIL] %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    function automatic logic [31:0] exp_psw(input logic [1:0] c);
        return (c != 2'h0) ? `CRSI_PSW_GUARDED : `CRSI_PSW_PLAIN;
    endfunction
    task bus(input logic w, input logic [8:0] a, input logic [31:0] d, input logic cut);
        begin
            @(posedge clk_i);
            addr <= a;
            wdat <= d;
            wr <= w;
            rd <= !w;
            n = 0;
            @(posedge clk_i);
            // The pin drops just after this edge so that its falling edge meets the accepted write.
            if (cut)
                ext_n <= 1'b0;
            while (wreq !== 1'b0 && n < 40)
            begin
                @(posedge clk_i);
                n++;
            end
            if (n >= 40)
            begin
                failures++;
                stop_test;
            end
            q = rdat;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task wait_start;
        begin
            repeat (3) @(posedge clk_i);
            n = 0;
            while (start_q !== 1'b1 && n < 200)
            begin
                @(posedge clk_i);
                n++;
            end
            if (n >= 200)
            begin
                failures++;
                stop_test;
            end
        end
    endtask
    task ram_check;
        for (i = 0; i < 12; i++)
        begin
            bus(0, 9'h140 + i * 16, 0, 0);
            chk("ram", mem[i], q);
        end
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        wait_start;
        chk("pc", `CRSI_PC_RST, pc_q);
        chk("psw", exp_psw(2'h0), psw_q);
        chk("zero out", `CRSI_ZERO_RST, zero_q);
        chk("ecr out", `CRSI_ECR_RST, ecr_q);
        bus(0, `CRSI_OFS_ZERO, 0, 0);
        chk("zero", `CRSI_ZERO_RST, q);
        bus(0, `CRSI_OFS_ECR, 0, 0);
        chk("ecr", `CRSI_ECR_RST, q);
        bus(0, 9'h024, 0, 0);
        chk("unmapped", 32'h00000000, q);
        bus(0, 9'h10C, 0, 0);
        chk("scratch", `CRSI_BOOT_MARK | 32'h00000003, q);
        for (i = 0; i < 12; i++)
        begin
            mem[i] = $random(seed);
            bus(1, 9'h140 + i * 16, mem[i], 0);
        end
        $display("test boot done");
        // Only the word being written when the pin falls is hit; every other word must survive.
        mem[1] = $random(seed);
        bus(1, 9'h150, mem[1], 1);
        mem[1] = mem[1] ^ `CRSI_CORRUPT_MASK;
        repeat (3) @(posedge clk_i);
        ext_n <= 1'b1;
        wait_start;
        bus(0, 9'h150, 0, 0);
        chk("cut word", mem[1], q);
        ram_check;
        $display("test external cut done");
        for (s = 0; s < 4; s++)
        begin
            vec = $random(seed);
            bus(1, `CRSI_OFS_CTRL, s, 0);
            bus(1, `CRSI_OFS_VECTOR, vec, 0);
            if (s == 2)
                bus(1, `CRSI_OFS_SWRESET, $random(seed), 0);
            else
            begin
                @(posedge clk_i);
                wdt_i <= (s == 0);
                cm_i <= (s == 1);
                por_i <= (s == 3);
                #1 chk("start cleared", 32'h00000000, {31'h00000000, start_q});
                repeat (3) @(posedge clk_i);
                chk("in reset", 32'h00000001, {31'h00000000, inrst_q});
                wdt_i <= 1'b0;
                cm_i <= 1'b0;
                por_i <= 1'b0;
            end
            wait_start;
            chk("pc", vec, pc_q);
            chk("psw", exp_psw(s[1:0]), psw_q);
            if (s < 3)
                ram_check;
            $display("test source %0d done", s);
        end
        stop_test;
    end
    initial
    begin
        #200000;
        failures++;
        stop_test;
    end
endmodule
`default_nettype wire
